// file: logic/swcd_decoder.sv
/*
  sweep command decoder: holds the 16-bit control word, decodes its top
  nibble into sweep and power commands, sequences settling and
  measurement, and keeps the status flags. assumes the serial register
  interface hands over complete control words as one-clock write
  strobes, and that start, step, point count and settling registers live
  beside this block, untouched by its reset command.
*/
// How it works
// - top four control bits pick nop, init, start, increment, repeat, power modes
// - init drives start frequency indefinitely, no measuring, until start sweep
// - start sweep waits programmed settling cycles before first conversion
// - increment steps frequency then waits settling cycles before converting
// - repeat re-measures current point without advancing frequency
// - after power-up block is in power-down, control word holds 0xa000
// - power-down ties excitation output and response input to ground
// - standby powers circuitry but keeps both pins grounded
// - reset aborts sweep, start, step and point count untouched
// - a control field selects excitation voltage range
// - a gain bit selects response gain of five or one
// - valid flag sets on point done, clears on start/increment/repeat commands and reset, not on init
// - sweep-complete flag sets after all increments, clears at reset
`timescale 1ns/1ps
`include "swcd_map.svh"
module swcd_decoder
  import swcd_pkg::*;
#(
  parameter int FREQ_W = 24,  // frequency word width
  parameter int PTS_W  = 9    // number of increments width
) (
  input  wire logic              core_clk,      // system clock
  input  wire logic              nrst,          // async reset, active low
  input  wire logic              ctrl_wr,       // control word write strobe
  input  wire logic [15:0]       ctrl_wdata,    // control word written
  input  wire logic [FREQ_W-1:0] start_freq,    // start frequency code
  input  wire logic [FREQ_W-1:0] freq_step,     // frequency increment code
  input  wire logic [PTS_W-1:0]  num_incr,      // number of increments
  input  wire swcd_settle_t      settle,        // settling cycles, mult
  input  wire logic              exc_tick,      // excitation period pulse
  input  wire logic              adc_done,      // conversion finished pulse
  output logic [15:0]            ctrl_rdata,    // control word readback
  output swcd_status_t           status,        // sweep done, data valid
  output logic [FREQ_W-1:0]      freq_word,     // frequency to generator
  output logic                   exc_enable,    // generator running
  output logic                   excitation_output_gnd, // output grounded
  output logic                   response_input_gnd,    // input grounded
  output logic                   analog_pwr_on, // analog circuitry powered
  output logic                   adc_start,     // conversion start pulse
  output logic [1:0]             exc_range,     // excitation range select
  output logic                   gain_x1        // 1: gain x1, 0: gain x5
);
  swcd_state_t       state_reg;
  swcd_state_t       state_next;
  swcd_pwr_t         pwr_reg;
  logic [PTS_W-1:0]  pts_reg;
  logic              settle_done;
  logic              settle_load;
  logic [3:0]        cmd;
  logic              rst_cmd;
  logic              do_init;
  logic              do_start;
  logic              do_incr;
  logic              do_rep;
  logic              meas_done;
  logic              last_point;

  // field pick shared by decode and command strobes
  function automatic logic is_cmd(input logic [3:0] c,
                                  input logic [3:0] code);
    return c == code;
  endfunction : is_cmd

  assign cmd      = ctrl_wdata[`SWCD_CMD_MSB:`SWCD_CMD_LSB];
  assign rst_cmd  = ctrl_wr && ctrl_wdata[`SWCD_RESET_BIT];
  assign do_init  = ctrl_wr && !rst_cmd && is_cmd(cmd, `SWCD_CMD_INIT);
  assign do_start = ctrl_wr && !rst_cmd && is_cmd(cmd, `SWCD_CMD_START);
  assign do_incr  = ctrl_wr && !rst_cmd && is_cmd(cmd, `SWCD_CMD_INCR);
  assign do_rep   = ctrl_wr && !rst_cmd && is_cmd(cmd, `SWCD_CMD_REPEAT);
  assign meas_done  = (state_reg == SWCD_ST_MEASURE) && adc_done;
  // point count saturates: increments past the end only re-measure
  assign last_point = pts_reg >= num_incr;

  // every settling wait goes through one counter
  assign settle_load = (state_next == SWCD_ST_SETTLE)
                       && (do_start || do_incr || do_rep);

  swcd_settle_cnt u_settle (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (settle_load),
    .abort    (rst_cmd),
    .tick     (exc_tick),
    .settle   (settle),
    .done     (settle_done)
  );

  // sweep sequencer; start is honoured only from the excite and hold states, so a
  // host skipping init after a reset sees no sweep, though the part goes active
  always_comb begin
    state_next = state_reg;
    if (rst_cmd) begin
      state_next = SWCD_ST_IDLE;
    end else begin
      case (state_reg)
        SWCD_ST_IDLE: begin
          if (do_init) state_next = SWCD_ST_EXCITE;
        end
        SWCD_ST_EXCITE: begin
          if (do_start) state_next = SWCD_ST_SETTLE;
        end
        SWCD_ST_SETTLE: begin
          if (settle_done) state_next = SWCD_ST_MEASURE;
        end
        SWCD_ST_MEASURE: begin
          if (adc_done) state_next = SWCD_ST_HOLD;
        end
        SWCD_ST_HOLD: begin
          if (do_incr || do_rep) state_next = SWCD_ST_SETTLE;
          else if (do_start) state_next = SWCD_ST_SETTLE;
        end
        default: state_next = SWCD_ST_IDLE;
      endcase
      if (do_init) state_next = SWCD_ST_EXCITE;
      if (pwr_reg != SWCD_PWR_ACTIVE && !(do_init || do_start || do_incr
          || do_rep) && ctrl_wr && (is_cmd(cmd, `SWCD_CMD_PDOWN)
          || is_cmd(cmd, `SWCD_CMD_STBY)))
        state_next = SWCD_ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) state_reg <= SWCD_ST_IDLE;
    else       state_reg <= state_next;
  end

  // control word store; reset bit is a strobe and never reads back
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_rdata <= `SWCD_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_rdata <= ctrl_wdata & ~(16'h0001 << `SWCD_RESET_BIT);
    end
  end

  // power mode: sweep commands wake the part, pdown/stby codes park it,
  // nop codes touch nothing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_reg <= SWCD_PWR_DOWN;
    end else if (ctrl_wr && !rst_cmd) begin
      case (cmd)
        `SWCD_CMD_PDOWN: pwr_reg <= SWCD_PWR_DOWN;
        `SWCD_CMD_STBY:  pwr_reg <= SWCD_PWR_STBY;
        `SWCD_CMD_INIT, `SWCD_CMD_START,
        `SWCD_CMD_INCR, `SWCD_CMD_REPEAT: pwr_reg <= SWCD_PWR_ACTIVE;
        default: pwr_reg <= pwr_reg;
      endcase
    end
  end

  // frequency word and point count; repeat keeps both
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      freq_word <= '0;
      pts_reg   <= '0;
    end else if (do_init) begin
      freq_word <= start_freq;
      pts_reg   <= '0;
    end else if (do_incr && state_reg == SWCD_ST_HOLD && !last_point) begin
      freq_word <= freq_word + freq_step;
      pts_reg   <= pts_reg + 1'b1;
    end
  end

  // status flags: a completing measurement beats a clearing command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      if (meas_done)
        status.data_valid <= 1'b1;
      else if (do_start || do_incr || do_rep || rst_cmd)
        status.data_valid <= 1'b0;
      if (meas_done && last_point)
        status.sweep_done <= 1'b1;
      else if (rst_cmd)
        status.sweep_done <= 1'b0;
    end
  end

  // conversion kick one clock after settling ends
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) adc_start <= 1'b0;
    else       adc_start <= settle_done && !rst_cmd;
  end

  // analog pin control; grounding follows the mode register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      excitation_output_gnd <= 1'b1;
      response_input_gnd    <= 1'b1;
      analog_pwr_on         <= 1'b0;
      exc_enable            <= 1'b0;
      exc_range             <= 2'h0;
      gain_x1               <= 1'b0;
    end else begin
      excitation_output_gnd <= pwr_reg != SWCD_PWR_ACTIVE;
      response_input_gnd    <= pwr_reg != SWCD_PWR_ACTIVE;
      analog_pwr_on         <= pwr_reg != SWCD_PWR_DOWN;
      exc_enable            <= pwr_reg == SWCD_PWR_ACTIVE
                               && state_reg != SWCD_ST_IDLE;
      exc_range <= ctrl_rdata[`SWCD_RANGE_MSB:`SWCD_RANGE_LSB];
      gain_x1   <= ctrl_rdata[`SWCD_GAIN_BIT];
    end
  end
endmodule : swcd_decoder

// file: logic/swcd_map.svh
/*
  constants of the sweep command decoder: control word fields, codes,
  reset values. assumes inclusion by the package and the design files.
*/
`ifndef SWCD_MAP_SVH
`define SWCD_MAP_SVH
`define SWCD_CTRL_RESET    16'ha000
`define SWCD_CMD_MSB       15
`define SWCD_CMD_LSB       12
`define SWCD_RANGE_MSB     10
`define SWCD_RANGE_LSB     9
`define SWCD_GAIN_BIT      8
`define SWCD_RESET_BIT     4
`define SWCD_CMD_NOP       4'h0
`define SWCD_CMD_INIT      4'h1
`define SWCD_CMD_START     4'h2
`define SWCD_CMD_INCR      4'h3
`define SWCD_CMD_REPEAT    4'h4
`define SWCD_CMD_PDOWN     4'ha
`define SWCD_CMD_STBY      4'hb
`define SWCD_MULT_X1       2'h0
`define SWCD_MULT_X2       2'h1
`define SWCD_MULT_X4       2'h3
`endif

// file: logic/swcd_pkg.sv
/*
  types of the sweep command decoder.
  assumes swcd_map.svh on the include path.
*/
`include "swcd_map.svh"
package swcd_pkg;
  typedef enum logic [1:0] {
    SWCD_PWR_DOWN   = 2'b00,
    SWCD_PWR_STBY   = 2'b01,
    SWCD_PWR_ACTIVE = 2'b10
  } swcd_pwr_t;

  typedef enum logic [2:0] {
    SWCD_ST_IDLE    = 3'b000,
    SWCD_ST_EXCITE  = 3'b001,
    SWCD_ST_SETTLE  = 3'b010,
    SWCD_ST_MEASURE = 3'b011,
    SWCD_ST_HOLD    = 3'b100
  } swcd_state_t;

  typedef struct packed {
    logic sweep_done;
    logic data_valid;
  } swcd_status_t;

  typedef struct packed {
    logic [1:0] mult;
    logic [8:0] cycles;
  } swcd_settle_t;
endpackage : swcd_pkg

// file: logic/swcd_settle_cnt.sv
/*
  settling counter: counts excitation cycle ticks up to cycles*mult,
  then pulses done for one clock. assumes tick is a one-clock pulse on
  core_clk, one per excitation period.
*/
`timescale 1ns/1ps
`include "swcd_map.svh"
module swcd_settle_cnt
  import swcd_pkg::*;
(
  input  wire logic         core_clk,  // system clock
  input  wire logic         nrst,      // async reset, active low
  input  wire logic         load,      // start a new settling wait
  input  wire logic         abort,     // drop a running wait
  input  wire logic         tick,      // one excitation period elapsed
  input  wire swcd_settle_t settle,    // programmed count and multiplier
  output logic              done       // one-clock pulse at end of wait
);
  logic [10:0] remain_reg;
  logic        run_reg;
  logic [10:0] target;

  // reserved multiplier code falls back to x1 rather than an odd scale
  always_comb begin
    case (settle.mult)
      `SWCD_MULT_X2: target = {1'b0, settle.cycles, 1'b0};
      `SWCD_MULT_X4: target = {settle.cycles, 2'b00};
      default:       target = {2'b00, settle.cycles};
    endcase
  end

  // count down ticks; a zero count finishes on the first tick
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      remain_reg <= 11'h000;
      run_reg    <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        run_reg <= 1'b0;
      end else if (load) begin
        remain_reg <= target;
        run_reg    <= 1'b1;
      end else if (run_reg && tick) begin
        if (remain_reg <= 11'h001) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end else begin
          remain_reg <= remain_reg - 11'h001;
        end
      end
    end
  end
endmodule : swcd_settle_cnt

// file: test/swcd_decoder_monitor.sv
/*
  port checker for swcd_decoder.
  assumes the bind after endmodule and one core_clk domain.
*/
`timescale 1ns/1ps
module swcd_decoder_monitor
  import swcd_pkg::*;
#(
  parameter int FREQ_W = 24  // frequency word width
) (
  input wire logic              core_clk,   // clock
  input wire logic              nrst,       // reset
  input wire logic              ctrl_wr,    // write strobe
  input wire logic [15:0]       ctrl_wdata, // written word
  input wire logic [FREQ_W-1:0] start_freq, // start code
  input wire logic              adc_done,   // conversion end
  input wire logic [15:0]       ctrl_rdata, // readback
  input wire swcd_status_t      status,     // flags
  input wire logic [FREQ_W-1:0] freq_word,  // frequency out
  input wire logic              exc_enable, // generator on
  input wire logic              excitation_output_gnd, // out gnd
  input wire logic              response_input_gnd,    // in gnd
  input wire logic              analog_pwr_on,         // powered
  input wire logic              adc_start,  // conversion start
  input wire logic [1:0]        exc_range,  // range
  input wire logic              gain_x1     // gain
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // readback drops the self-clearing reset bit
  a_word_stored: assert property (ctrl_wr |=> ctrl_rdata ==
    {$past(ctrl_wdata[15:5]), 1'b0, $past(ctrl_wdata[3:0])})
    else $error("control readback wrong");
  a_range_copy: assert property (ctrl_wr |-> ##2
    exc_range == $past(ctrl_wdata[10:9], 2)) else $error("range wrong");
  a_gain_copy: assert property (ctrl_wr |-> ##2
    gain_x1 == $past(ctrl_wdata[8], 2)) else $error("gain wrong");
  a_init_runs: assert property ((ctrl_wr && ctrl_wdata[15:12] == 4'h1
    && !ctrl_wdata[4]) |-> ##2 exc_enable && freq_word == start_freq)
    else $error("init did not run start frequency");
  a_pdown_gnd: assert property ((ctrl_wr && ctrl_wdata[15:12] == 4'ha)
    |-> ##2 excitation_output_gnd && response_input_gnd && !analog_pwr_on)
    else $error("power-down not grounded");
  a_stby_gnd: assert property ((ctrl_wr && ctrl_wdata[15:12] == 4'hb)
    |-> ##2 excitation_output_gnd && response_input_gnd && analog_pwr_on)
    else $error("standby state wrong");
  a_unpowered_gnd: assert property (!analog_pwr_on |->
    excitation_output_gnd && response_input_gnd && !exc_enable)
    else $error("pins live while unpowered");
  a_valid_sets: assert property (adc_done |=> status.data_valid)
    else $error("valid flag not set");
  a_reset_flags: assert property ((ctrl_wr && ctrl_wdata[4] && !adc_done)
    |=> status == 2'b00) else $error("reset left flags");
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start too long");
  a_nop_holds: assert property ((ctrl_wr && ctrl_wdata[15:12] == 4'h0
    && !ctrl_wdata[4]) |=> ($stable(freq_word) && $stable(analog_pwr_on))[*2])
    else $error("no-op changed state");
endmodule : swcd_decoder_monitor

bind swcd_decoder swcd_decoder_monitor #(
  .FREQ_W (FREQ_W)
) u_swcd_decoder_monitor (
  .core_clk              (core_clk),
  .nrst                  (nrst),
  .ctrl_wr               (ctrl_wr),
  .ctrl_wdata            (ctrl_wdata),
  .start_freq            (start_freq),
  .adc_done              (adc_done),
  .ctrl_rdata            (ctrl_rdata),
  .status                (status),
  .freq_word             (freq_word),
  .exc_enable            (exc_enable),
  .excitation_output_gnd (excitation_output_gnd),
  .response_input_gnd    (response_input_gnd),
  .analog_pwr_on         (analog_pwr_on),
  .adc_start             (adc_start),
  .exc_range             (exc_range),
  .gain_x1               (gain_x1)
);

// file: test/swcd_far_model.sv
/*
  far side of the decoder: excitation period ticks and conversion ends.
  assumes the same core_clk as the decoder.
*/
`timescale 1ns/1ps
module swcd_far_model (
  input  wire logic core_clk,   // clock
  input  wire logic nrst,       // reset
  input  wire logic exc_enable, // generator running
  input  wire logic adc_start,  // conversion start
  output logic      exc_tick,   // one pulse per period
  output logic      adc_done    // conversion finished
);
  logic [1:0] per_reg;
  logic [2:0] conv_reg;
  // period of four clocks, stopped while the generator is off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      per_reg  <= 2'h0;
      conv_reg <= 3'h0;
    end else begin
      per_reg  <= exc_enable ? per_reg + 2'h1 : 2'h0;
      conv_reg <= {conv_reg[1:0], adc_start};  // three-clock conversion
    end
  end
  assign exc_tick = exc_enable && (per_reg == 2'h3);
  assign adc_done = conv_reg[2];
endmodule : swcd_far_model

// file: test/swcd_decoder_tb_top.sv
/*
  self-checking bench for swcd_decoder.
  assumes swcd_far_model and the bound monitor.
*/
`timescale 1ns/1ps
module swcd_decoder_tb_top
  import swcd_pkg::*;
;
  logic         core_clk = 1'b0;
  logic         nrst = 1'b0;
  logic         ctrl_wr = 1'b0;
  logic [15:0]  ctrl_wdata = 16'h0000;
  logic [23:0]  start_freq = 24'h012345;
  logic [23:0]  freq_step = 24'h000100;
  logic [8:0]   num_incr = 9'h001;
  swcd_settle_t settle = '{mult: 2'h1, cycles: 9'h003};  // six ticks
  logic         exc_tick, adc_done, exc_enable, og, ig, pwr, adc_start;
  logic         gain_x1;
  logic [1:0]   exc_range;
  logic [15:0]  ctrl_rdata;
  logic [23:0]  freq_word;
  swcd_status_t status;
  int           n_mismatch = 0, n_compared = 0, cyc = 0, nt = 0;

  swcd_decoder u_swcd_decoder (.core_clk(core_clk), .nrst(nrst),
    .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .start_freq(start_freq),
    .freq_step(freq_step), .num_incr(num_incr), .settle(settle),
    .exc_tick(exc_tick), .adc_done(adc_done), .ctrl_rdata(ctrl_rdata),
    .status(status), .freq_word(freq_word), .exc_enable(exc_enable),
    .excitation_output_gnd(og), .response_input_gnd(ig),
    .analog_pwr_on(pwr), .adc_start(adc_start), .exc_range(exc_range),
    .gain_x1(gain_x1));
  swcd_far_model u_swcd_far_model (.core_clk(core_clk), .nrst(nrst),
    .exc_enable(exc_enable), .adc_start(adc_start), .exc_tick(exc_tick),
    .adc_done(adc_done));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  // one-clock strobe, launched and dropped on falling edges
  task wr(input logic [15:0] d);
    @(negedge core_clk);
    ctrl_wr = 1'b1;
    ctrl_wdata = d;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
  endtask : wr

  // bounded wait for a conversion start, counting ticks meanwhile; the
  // tick seen at the first edge after the write is counted too
  task wait_meas;
    int k;
    nt = 0;
    for (k = 0; k < 300 && adc_start !== 1'b1; k++) begin
      if (exc_tick === 1'b1) nt++;
      @(negedge core_clk);
    end
    chk(k < 300, 24'h1);
    idle(8);
  endtask : wait_meas

  task t_power_up;
    chk(ctrl_rdata, 24'h00a000);
    chk(status, 24'h0);
    chk({og, ig, pwr}, 24'h6);
  endtask : t_power_up

  task t_standby;
    wr(16'hb000);
    idle(1);
    chk({og, ig, pwr}, 24'h7);
    chk(ctrl_rdata, 24'h00b000);
  endtask : t_standby

  task t_sweep;
    wr(16'h1500);
    idle(20);
    chk(freq_word, start_freq);
    chk({exc_enable, og, status}, 24'h8);
    chk({exc_range, gain_x1}, 24'h5);
    wr(16'h2000);
    wait_meas;
    chk(nt == 6, 24'h1);
    chk(status, 24'h1);
    wr(16'h3000);
    chk(status.data_valid, 24'h0);
    idle(1);
    chk(freq_word, start_freq + freq_step);
    wait_meas;
    chk(status, 24'h3);
    wr(16'h4000);
    wait_meas;
    chk(freq_word, start_freq + freq_step);
    chk(status.data_valid, 24'h1);
    wr(16'h0000);
    idle(2);
    chk(freq_word, start_freq + freq_step);
    chk(exc_enable, 24'h1);
  endtask : t_sweep

  task t_reset_cmd;
    wr(16'h0010);
    idle(1);
    chk(status, 24'h0);
    chk(ctrl_rdata, 24'h0);
    wr(16'h2000);
    idle(40);
    chk(status, 24'h0);
    wr(16'ha000);
    idle(1);
    chk({og, ig, pwr, exc_enable}, 24'hc);
  endtask : t_reset_cmd

  // multiplier decode: x4 on a start, reserved code acts as x1 on repeat
  task t_settle_mult;
    settle = '{mult: 2'h3, cycles: 9'h001};
    wr(16'h1000);
    idle(4);
    chk(freq_word, start_freq);
    wr(16'h2000);
    wait_meas;
    chk(nt == 4, 24'h1);
    chk(status, 24'h1);
    settle = '{mult: 2'h2, cycles: 9'h003};
    wr(16'h4000);
    chk(status.data_valid, 24'h0);
    wait_meas;
    chk(nt == 3, 24'h1);
    chk(freq_word, start_freq);
    chk(status.data_valid, 24'h1);
  endtask : t_settle_mult

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  // hang guard, well above the few hundred clocks the scenarios need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out;
    end
  end

  initial begin
    idle(4);
    nrst = 1'b1;
    idle(1);
    t_power_up;
    t_standby;
    t_sweep;
    t_reset_cmd;
    t_settle_mult;
    close_out;
  end
endmodule : swcd_decoder_tb_top
